// ### pkg/kwd_pkg.sv
/*
 Constants for the keyed watchdog: register offsets, field positions,
 access keys, divider masks and pulse length.
 Assumes a single 10 MHz clock domain and byte addresses on the bus.
*/
package kwd_pkg;

    // ****************
    // Register map
    // ****************
    localparam logic [3:0] OFS_MODE = 4'h0;
    localparam logic [3:0] OFS_CLOCK = 4'h4;
    localparam logic [3:0] OFS_RESTART = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;

    // ****************
    // Fields and keys
    // ****************
    localparam int BIT_RUN_EN = 0;
    localparam int BIT_RST_EN = 1;
    localparam int BIT_IRQ_EN = 2;
    localparam int BIT_PIN_EN = 3;
    localparam logic [11:0] MODE_WRITE_KEY = 12'h234;
    localparam logic [8:0] CLOCK_WRITE_KEY = 9'h06e;
    localparam logic [15:0] RESTART_KEY = 16'hc071;
    localparam logic [11:0] PRELOAD_LOW = 12'hfff;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic [5:0] CLOCK_RESET = 6'h00;

    // ****************
    // Timing
    // ****************
    localparam logic [11:0] DIV32_MASK = 12'h01f;
    localparam logic [11:0] DIV128_MASK = 12'h07f;
    localparam logic [11:0] DIV1024_MASK = 12'h3ff;
    localparam logic [11:0] DIV4096_MASK = 12'hfff;
    localparam logic [3:0] PIN_PULSE_CYCLES = 4'h8;

endpackage

// ### rtl/kwd_presc.sv
/*
 Count clock prescaler for the keyed watchdog.
 Assumes the select input is a register in the same clock domain.
*/
`timescale 1ns/1ps
module kwd_presc (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic [1:0] sel,
    output logic tick
);

    logic [11:0] cnt_q;
    logic tick_q;
    logic [11:0] mask;
    logic tick_d;

    // Select masks, one per divider
    assign mask = (sel == 2'h0) ? kwd_pkg::DIV32_MASK :
                  (sel == 2'h1) ? kwd_pkg::DIV128_MASK :
                  (sel == 2'h2) ? kwd_pkg::DIV1024_MASK :
                  kwd_pkg::DIV4096_MASK;
    // One tick each time the low bits wrap
    assign tick_d = !clear && ((cnt_q & mask) == mask);
    assign tick = tick_q;

    // Cleared on restart so the first period is a full one
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 12'h000;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= clear ? 12'h000 : cnt_q + 12'h001;
            tick_q <= tick_d;
        end
    end

endmodule

// ### rtl/kwd_top.sv
/*
 Keyed watchdog timer with an Avalon-MM slave for its four registers.
 Assumes one 10 MHz clock, an active-low asynchronous reset and a
 master that holds each request until waitrequest is seen low.
*/
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module kwd_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic system_reset_request,
    output logic timeout_interrupt_pulse,
    output logic overflow_alert_pin_n
);

    // ****************
    // State
    // ****************
    logic wait_q;
    logic [31:0] rdata_q;
    logic [3:0] mode_q;
    logic [5:0] clock_q;
    logic [15:0] cnt_q;
    logic flag_q;
    logic sysrst_q;
    logic irq_q;
    logic [3:0] pcnt_q;
    logic pin_n_q;

    // ****************
    // Bus decode
    // ****************
    logic req;
    logic wr_go;
    logic rd_take;
    logic low_half;
    logic hit_mode;
    logic hit_clock;
    logic hit_restart;
    logic hit_status;
    logic mode_key_ok;
    logic clock_key_ok;
    logic mode_wr;
    logic clock_wr;
    logic restart;
    logic [31:0] rdata_d;

    assign req = avs_read || avs_write;
    // Writes act at the edge where waitrequest is low; reads latch data while it is high
    assign wr_go = avs_write && !wait_q;
    assign rd_take = avs_read && wait_q;
    // Keys and fields all sit in bytes 0 and 1
    assign low_half = (avs_byteenable[1:0] == 2'h3);
    assign hit_mode = (avs_address == kwd_pkg::OFS_MODE);
    assign hit_clock = (avs_address == kwd_pkg::OFS_CLOCK);
    assign hit_restart = (avs_address == kwd_pkg::OFS_RESTART);
    assign hit_status = (avs_address == kwd_pkg::OFS_STATUS);
    assign mode_key_ok =
        (avs_writedata[15:4] == kwd_pkg::MODE_WRITE_KEY);
    assign clock_key_ok =
        (avs_writedata[15:7] == kwd_pkg::CLOCK_WRITE_KEY);
    assign mode_wr = wr_go && low_half && hit_mode && mode_key_ok;
    assign clock_wr = wr_go && low_half && hit_clock && clock_key_ok;
    assign restart = wr_go && low_half && hit_restart &&
        (avs_writedata[15:0] == kwd_pkg::RESTART_KEY);

    // Key fields never read back; restart reads as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_mode) begin
            rdata_d[3:0] = mode_q;
        end else if (hit_clock) begin
            rdata_d[5:0] = clock_q;
        end else if (hit_status) begin
            rdata_d[0] = flag_q;
        end
    end

    // One wait cycle per access, accepted or refused alike
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(req && wait_q);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;

    // ****************
    // Configuration
    // ****************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= kwd_pkg::MODE_RESET;
            clock_q <= kwd_pkg::CLOCK_RESET;
        end else begin
            if (mode_wr) begin
                mode_q <= avs_writedata[3:0];
            end
            if (clock_wr) begin
                clock_q <= avs_writedata[5:0];
            end
        end
    end

    logic run_en;
    logic rst_en;
    logic irq_en;
    logic pin_en;
    logic [1:0] clk_sel;
    logic [3:0] preload_nibble;
    logic [15:0] preload;

    assign run_en = mode_q[kwd_pkg::BIT_RUN_EN];
    assign rst_en = mode_q[kwd_pkg::BIT_RST_EN];
    assign irq_en = mode_q[kwd_pkg::BIT_IRQ_EN];
    assign pin_en = mode_q[kwd_pkg::BIT_PIN_EN];
    assign clk_sel = clock_q[1:0];
    assign preload_nibble = clock_q[5:2];
    assign preload = {preload_nibble, kwd_pkg::PRELOAD_LOW};

    // ****************
    // Counter
    // ****************
    logic tick;
    logic ovf_ev;
    logic [15:0] cnt_d;

    kwd_presc u_presc (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clear(restart),
        .sel(clk_sel),
        .tick(tick)
    );

    // Passing zero while enabled is the timeout
    assign ovf_ev = tick && run_en && !restart &&
        (cnt_q == 16'h0000);

    // Counter reloads after a timeout and keeps guarding
    always_comb begin
        cnt_d = cnt_q;
        if (restart || ovf_ev) begin
            cnt_d = preload;
        end else if (tick && run_en) begin
            cnt_d = cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Clear from a restart wins; a restart blocks ovf_ev in the same cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else if (ovf_ev) begin
            flag_q <= 1'b1;
        end else if (restart) begin
            flag_q <= 1'b0;
        end
    end

    // ****************
    // Overflow outputs
    // ****************
    logic [3:0] pcnt_d;
    logic pin_n_d;

    assign pcnt_d = (ovf_ev && pin_en) ? kwd_pkg::PIN_PULSE_CYCLES :
                    (pcnt_q != 4'h0) ? pcnt_q - 4'h1 : 4'h0;
    assign pin_n_d = (pcnt_d == 4'h0);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sysrst_q <= 1'b0;
            irq_q <= 1'b0;
            pcnt_q <= 4'h0;
            pin_n_q <= 1'b1;
        end else begin
            sysrst_q <= ovf_ev && rst_en;
            irq_q <= ovf_ev && irq_en;
            pcnt_q <= pcnt_d;
            pin_n_q <= pin_n_d;
        end
    end

    // Reset request is a single pulse; the reset block stretches it
    assign system_reset_request = sysrst_q;
    assign timeout_interrupt_pulse = irq_q;
    assign overflow_alert_pin_n = pin_n_q;

    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_pin_low8;
        !overflow_alert_pin_n [*8];
    endsequence

    sequence s_pin_release;
        overflow_alert_pin_n;
    endsequence

    property p_disabled_quiet;
        !run_en |=> !system_reset_request && !timeout_interrupt_pulse;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("overflow output while disabled");

    property p_reset_req;
        system_reset_request |-> $past(ovf_ev) && $past(rst_en);
    endproperty
    a_reset_req: assert property (p_reset_req)
        else $error("reset request without enabled overflow");

    property p_irq_cause;
        ovf_ev && irq_en |=> timeout_interrupt_pulse;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt missing after overflow");

    property p_pin_pulse;
        ovf_ev && pin_en |=> s_pin_low8 ##1 s_pin_release;
    endproperty
    a_pin_pulse: assert property (p_pin_pulse)
        else $error("alert pin pulse not eight cycles");

    property p_pin_quiet;
        $fell(overflow_alert_pin_n) |-> $past(ovf_ev) && $past(pin_en);
    endproperty
    a_pin_quiet: assert property (p_pin_quiet)
        else $error("alert pin fell without enabled overflow");

    property p_mode_key;
        wr_go && hit_mode && !mode_key_ok |=> $stable(mode_q);
    endproperty
    a_mode_key: assert property (p_mode_key)
        else $error("mode changed by bad key");

    property p_clock_key;
        wr_go && hit_clock && !clock_key_ok |=> $stable(clock_q);
    endproperty
    a_clock_key: assert property (p_clock_key)
        else $error("clock mode changed by bad key");

    property p_key_read_zero;
        !avs_waitrequest |-> avs_readdata[31:6] == 26'h0;
    endproperty
    a_key_read_zero: assert property (p_key_read_zero)
        else $error("key field read back nonzero");

    property p_restart_load;
        restart |=> cnt_q == {$past(preload_nibble), 12'hfff};
    endproperty
    a_restart_load: assert property (p_restart_load)
        else $error("restart loaded wrong value");

    property p_count_down;
        tick && run_en && !restart && cnt_q != 16'h0000
            |=> cnt_q == $past(cnt_q) - 16'h0001;
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("counter did not decrement");

    property p_flag_set;
        ovf_ev |=> flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("overflow flag not set");

    property p_irq_pulse;
        timeout_interrupt_pulse |=> !timeout_interrupt_pulse;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt held longer than one cycle");

    property p_bus_answer;
        req && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus access not answered in one cycle");

endmodule

// ### dv/kwd_tb.sv
/*
 Self-checking bench for the keyed watchdog top.
 Assumes kwd_top with Avalon-MM answering one cycle after each request.
*/
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic system_reset_request;
    logic timeout_interrupt_pulse;
    logic overflow_alert_pin_n;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0 = 0;
    int t_ovf = 0;
    int low_n = 0;
    logic pin_prev = 1'b1;
    logic irq_prev = 1'b0;
    logic [31:0] seed = 32'h2d14;
    logic [31:0] rd_q[$];
    logic [2:0] ev_q[$];

    kwd_top i_dut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .system_reset_request(system_reset_request),
        .timeout_interrupt_pulse(timeout_interrupt_pulse),
        .overflow_alert_pin_n(overflow_alert_pin_n)
    );

    always #50 ref_clk = ~ref_clk;

    // ****************
    // Checking
    // ****************
    task automatic give_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_win(input int g, input int lo, input int hi);
        n_checks++;
        if (g < lo || g > hi) begin
            n_errors++;
            $display("mismatch at %0t: interval %0d", $time, g);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Watches outputs and takes the oldest note
    always @(posedge ref_clk) begin
        if (nrst) begin
            if (avs_read && !avs_waitrequest) begin
                chk(avs_readdata, rd_q.size() ? rd_q.pop_front() : 32'hx);
            end
            if (system_reset_request || timeout_interrupt_pulse ||
                (!overflow_alert_pin_n && pin_prev)) begin
                chk({29'h0, system_reset_request, timeout_interrupt_pulse,
                    ~overflow_alert_pin_n}, ev_q.size() ? ev_q.pop_front() : 0);
                t_ovf = cyc;
            end
            if (timeout_interrupt_pulse) begin
                chk(irq_prev, 1'b0);
            end
            if (!overflow_alert_pin_n) begin
                low_n++;
            end else if (low_n != 0) begin
                chk(low_n, 8);
                low_n = 0;
            end
            pin_prev = overflow_alert_pin_n;
            irq_prev = timeout_interrupt_pulse;
        end
        cyc++;
    end

    // ****************
    // Bus tasks
    // ****************
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest && n < 50);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            n_errors++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        seed = xs(seed);
        bus(1'b1, a, {seed[31:16], d[15:0]}, 4'hf);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial begin
        int n;
        logic [15:0] k;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(4'h0, 0);
        rd(4'h4, 0);
        rd(4'hc, 0);
        rd(4'h2, 0);
        seed = xs(seed);
        k = (seed[11:0] == 12'h234) ? 16'h0 : {seed[11:0], 4'hf};
        wr(4'h0, k);
        rd(4'h0, 0);
        wr(4'h0, 32'h234e);
        rd(4'h0, 32'he);
        bus(1'b1, 4'h0, 32'h2341, 4'h1);
        rd(4'h0, 32'he);
        seed = xs(seed);
        k = (seed[8:0] == 9'h06e) ? 16'h3c : {seed[8:0], 7'h3c};
        wr(4'h4, k);
        rd(4'h4, 0);
        wr(4'h4, 32'h373c);
        rd(4'h4, 32'h3c);
        wr(4'h4, 32'h3700);
        rd(4'h4, 0);
        wr(4'hc, 32'h1);
        rd(4'hc, 0);
        wr(4'h0, 32'h2340);
        wr(4'h8, 32'hc071);
        ev_q.push_back(3'b111);
        wr(4'h0, 32'h234f);
        t0 = cyc;
        repeat (40000) @(posedge ref_clk);
        seed = xs(seed);
        wr(4'h8, (seed[15:0] == 16'hc071) ? 16'h0 : seed[15:0]);
        n = 0;
        while (t_ovf == 0 && n < 140000) begin
            @(posedge ref_clk);
            n++;
        end
        if (t_ovf == 0) begin
            n_errors++;
            give_verdict();
        end
        chk_win(t_ovf - t0, 131040, 131110);
        repeat (12) @(posedge ref_clk);
        rd(4'hc, 1);
        rd(4'h0, 32'hf);
        wr(4'h8, 32'hc071);
        rd(4'hc, 0);
        wr(4'h0, 32'h2340);
        rd(4'h0, 0);
        repeat (4) @(posedge ref_clk);
        chk(ev_q.size(), 0);
        chk(rd_q.size(), 0);
        give_verdict();
    end
endmodule
